// ---- common/uhq_pkg.sv ----
// shared constants and types of the serial receive-control block
package uhq_pkg;
  // register byte offsets
  localparam logic [7:0] UHQ_OFS_CTRL   = 8'h00;
  localparam logic [7:0] UHQ_OFS_MODE   = 8'h04;
  localparam logic [7:0] UHQ_OFS_STAT   = 8'h08;
  localparam logic [7:0] UHQ_OFS_MASK   = 8'h0c;
  localparam logic [7:0] UHQ_OFS_RXDATA = 8'h10;
  localparam logic [7:0] UHQ_OFS_ERRCNT = 8'h14;
  localparam logic [7:0] UHQ_OFS_STATE  = 8'h18;
  // control_reg command bit positions
  localparam int UHQ_CTL_RXRST   = 0;
  localparam int UHQ_CTL_RTSLOW  = 1;
  localparam int UHQ_CTL_RTSHIGH = 2;
  // mode_reg field positions and reset values
  localparam int         UHQ_MODE_LSB  = 0;
  localparam int         UHQ_CHLEN_LSB = 4;
  localparam logic [3:0] UHQ_CHLEN_RST = 4'h8;
  // status and mask bit positions
  localparam int UHQ_ST_RXRDY  = 0;
  localparam int UHQ_ST_SPIERR = 1;
  localparam int UHQ_ST_W      = 2;
  // receiver shift width, largest character length
  localparam int UHQ_SHIFT_W = 9;
  // least ratio of peripheral clock to external serial clock
  localparam int UHQ_SCK_RATIO_MIN = 9;
  // unblock progress after a transmit in t=1 mode
  localparam logic [1:0] UHQ_UNBLK_IDLE = 2'h0;
  localparam logic [1:0] UHQ_UNBLK_RST  = 2'h1;
  localparam logic [1:0] UHQ_UNBLK_MODE = 2'h2;
  // axi responses
  localparam logic [1:0] UHQ_RESP_OKAY   = 2'h0;
  localparam logic [1:0] UHQ_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    UHQ_NORMAL,
    UHQ_HANDSHAKE,
    UHQ_ISO_T1,
    UHQ_SPI_SLAVE
  } uhq_opmode_t;

  typedef struct packed {
    logic [3:0]  chlen;
    logic [1:0]  rsvd;
    uhq_opmode_t mode;
  } uhq_mode_t;

  typedef struct packed {
    logic sck;
    logic rxd;
    logic cs_n;
  } uhq_link_t;
endpackage

// ---- hdl/uhq_usart_rx_ctrl.sv ----
// receive-side control of the serial transceiver with axi4-lite registers
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
module uhq_usart_rx_ctrl #(
  parameter bit HS_FIXED = 1'b0
) (
  // clock, reset, enable
  input  wire logic              clock_i,
  input  wire logic              arst_n_i,
  input  wire logic              ce_i,
  // axi4-lite write address and data
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [7:0]        s_axi_awaddr_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  // axi4-lite write response
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  output logic [1:0]             s_axi_bresp_o,
  // axi4-lite read
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  input  wire logic [7:0]        s_axi_araddr_i,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  // serial link pins
  input  wire uhq_pkg::uhq_link_t link_i,
  output logic                   rts_o,
  // same-domain side signals
  input  wire logic              dma_rx_full_i,
  input  wire logic              tx_done_i,
  output logic                   irq_o
);

  logic                           rst_n;
  logic [1:0]                     rst_sync_ff;
  uhq_pkg::uhq_link_t             lnk_m_ff, lnk_s_ff, lnk_d_ff;
  logic                           aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
  logic [7:0]                     awaddr_ff;
  logic [31:0]                    wdata_ff, rdata_ff, nxt_rdata;
  logic                           wstrb0_ff;
  logic [1:0]                     bresp_ff, rresp_ff;
  uhq_pkg::uhq_mode_t             mode_ff;
  logic [uhq_pkg::UHQ_ST_W-1:0]   stat_ff, mask_ff, stat_set, stat_clr;
  logic                           force_ff, nxt_force, rts_ff, hs_raise;
  logic                           blocked_ff;
  logic [1:0]                     unblk_ff;
  logic [uhq_pkg::UHQ_SHIFT_W-1:0] shift_ff, rxdata_ff;
  logic [3:0]                     cnt_ff, cnt_inc;
  logic                           do_wr, wr_ctl, wr_mode, wr_stat, wr_mask, rd_take;
  logic                           is_spi, sck_rise, cs_rise, rx_en, tx_t1;

  // address decode shared by the read and write paths
  function automatic logic uhq_mapped(input logic [7:0] a);
    uhq_mapped = (a == uhq_pkg::UHQ_OFS_CTRL) || (a == uhq_pkg::UHQ_OFS_MODE) ||
                 (a == uhq_pkg::UHQ_OFS_STAT) || (a == uhq_pkg::UHQ_OFS_MASK) ||
                 (a == uhq_pkg::UHQ_OFS_RXDATA) || (a == uhq_pkg::UHQ_OFS_ERRCNT) ||
                 (a == uhq_pkg::UHQ_OFS_STATE);
  endfunction

  // keep only the low character-length bits; stale shift bits would leak above
  function automatic logic [uhq_pkg::UHQ_SHIFT_W-1:0] uhq_keep(
      input logic [uhq_pkg::UHQ_SHIFT_W-1:0] v, input logic [3:0] n);
    logic [uhq_pkg::UHQ_SHIFT_W-1:0] ones;
    ones     = '1;
    uhq_keep = v & ~(ones << n);
  endfunction

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // link pins: two-flop sync plus one delay stage for edge finding
  // relies on slow clock
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      lnk_m_ff <= 3'h1;
      lnk_s_ff <= 3'h1;
      lnk_d_ff <= 3'h1;
    end else if (ce_i) begin
      lnk_m_ff <= link_i;
      lnk_s_ff <= lnk_m_ff;
      lnk_d_ff <= lnk_s_ff;
    end
  end
  assign sck_rise = lnk_s_ff.sck & ~lnk_d_ff.sck;
  assign cs_rise  = lnk_s_ff.cs_n & ~lnk_d_ff.cs_n;

  // bus handshakes; one held address and one held data word
  assign s_axi_awready_o = ~aw_held_ff;
  assign s_axi_wready_o  = ~w_held_ff;
  assign s_axi_arready_o = ~rvalid_ff;
  assign s_axi_bvalid_o  = bvalid_ff;
  assign s_axi_bresp_o   = bresp_ff;
  assign s_axi_rvalid_o  = rvalid_ff;
  assign s_axi_rdata_o   = rdata_ff;
  assign s_axi_rresp_o   = rresp_ff;
  assign do_wr   = ce_i & aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wr_ctl  = do_wr & wstrb0_ff & (awaddr_ff == uhq_pkg::UHQ_OFS_CTRL);
  assign wr_mode = do_wr & wstrb0_ff & (awaddr_ff == uhq_pkg::UHQ_OFS_MODE);
  assign wr_stat = do_wr & wstrb0_ff & (awaddr_ff == uhq_pkg::UHQ_OFS_STAT);
  assign wr_mask = do_wr & wstrb0_ff & (awaddr_ff == uhq_pkg::UHQ_OFS_MASK);
  assign rd_take = ce_i & s_axi_arvalid_i & ~rvalid_ff;

  // write channel capture, either order
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb0_ff  <= 1'b0;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && !aw_held_ff) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr_i;
      end else if (do_wr) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid_i && !w_held_ff) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata_i;
        wstrb0_ff <= s_axi_wstrb_i[0];
      end else if (do_wr) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= uhq_pkg::UHQ_RESP_OKAY;
    end else if (ce_i) begin
      if (do_wr) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= uhq_mapped(awaddr_ff) ? uhq_pkg::UHQ_RESP_OKAY : uhq_pkg::UHQ_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // read mux; reserved bits read zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (s_axi_araddr_i == uhq_pkg::UHQ_OFS_MODE) begin
      nxt_rdata[7:0] = {mode_ff.chlen, 2'h0, mode_ff.mode};
    end else if (s_axi_araddr_i == uhq_pkg::UHQ_OFS_STAT) begin
      nxt_rdata[uhq_pkg::UHQ_ST_W-1:0] = stat_ff;
    end else if (s_axi_araddr_i == uhq_pkg::UHQ_OFS_MASK) begin
      nxt_rdata[uhq_pkg::UHQ_ST_W-1:0] = mask_ff;
    end else if (s_axi_araddr_i == uhq_pkg::UHQ_OFS_RXDATA) begin
      nxt_rdata[uhq_pkg::UHQ_SHIFT_W-1:0] = rxdata_ff;
    end else if (s_axi_araddr_i == uhq_pkg::UHQ_OFS_STATE) begin
      nxt_rdata[1:0] = {blocked_ff, rts_ff};
    end else begin
      nxt_rdata = 32'h0000_0000;
    end
  end

  // read response, one cycle after the address is taken
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= uhq_pkg::UHQ_RESP_OKAY;
    end else if (ce_i) begin
      if (rd_take) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= nxt_rdata;
        rresp_ff  <= uhq_mapped(s_axi_araddr_i) ? uhq_pkg::UHQ_RESP_OKAY : uhq_pkg::UHQ_RESP_SLVERR;
      end else if (s_axi_rready_i) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // mode and mask registers
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= '{chlen: uhq_pkg::UHQ_CHLEN_RST, rsvd: 2'h0, mode: uhq_pkg::UHQ_NORMAL};
      mask_ff <= '0;
    end else begin
      if (wr_mode) begin
        mode_ff.chlen <= wdata_ff[uhq_pkg::UHQ_CHLEN_LSB +: 4];
        mode_ff.mode  <= uhq_pkg::uhq_opmode_t'(wdata_ff[uhq_pkg::UHQ_MODE_LSB +: 2]);
      end
      if (wr_mask) begin
        mask_ff <= wdata_ff[uhq_pkg::UHQ_ST_W-1:0];
      end
    end
  end
  assign is_spi = (mode_ff.mode == uhq_pkg::UHQ_SPI_SLAVE);

  // request-to-send: force-high wins if both commands arrive together
  always_comb begin
    nxt_force = force_ff;
    if (wr_ctl && wdata_ff[uhq_pkg::UHQ_CTL_RTSHIGH]) begin
      nxt_force = 1'b1;
    end else if (wr_ctl && wdata_ff[uhq_pkg::UHQ_CTL_RTSLOW]) begin
      nxt_force = 1'b0;
    end
  end
  assign hs_raise = HS_FIXED & (mode_ff.mode == uhq_pkg::UHQ_HANDSHAKE) & dma_rx_full_i;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      force_ff <= 1'b0;
      rts_ff   <= 1'b0;
    end else if (ce_i) begin
      force_ff <= nxt_force;
      rts_ff   <= nxt_force | hs_raise;
    end
  end
  assign rts_o = rts_ff;

  // t=1 block: reset, then mode, then control write
  assign tx_t1 = ce_i & tx_done_i & (mode_ff.mode == uhq_pkg::UHQ_ISO_T1);
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      blocked_ff <= 1'b0;
      unblk_ff   <= uhq_pkg::UHQ_UNBLK_IDLE;
    end else if (tx_t1) begin
      blocked_ff <= 1'b1;
      unblk_ff   <= uhq_pkg::UHQ_UNBLK_IDLE;
    end else if (blocked_ff) begin
      if (wr_ctl && wdata_ff[uhq_pkg::UHQ_CTL_RXRST]) begin
        unblk_ff <= uhq_pkg::UHQ_UNBLK_RST;
      end else if (wr_mode && unblk_ff == uhq_pkg::UHQ_UNBLK_RST) begin
        unblk_ff <= uhq_pkg::UHQ_UNBLK_MODE;
      end else if (wr_ctl && unblk_ff == uhq_pkg::UHQ_UNBLK_MODE) begin
        blocked_ff <= 1'b0;
        unblk_ff   <= uhq_pkg::UHQ_UNBLK_IDLE;
      end
    end
  end

  // receiver shifts msb first on each rising serial clock edge
  assign rx_en   = ~blocked_ff & (~is_spi | ~lnk_s_ff.cs_n);
  assign cnt_inc = cnt_ff + 4'h1;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      shift_ff  <= '0;
      rxdata_ff <= '0;
      cnt_ff    <= 4'h0;
    end else if (ce_i) begin
      if (wr_ctl && wdata_ff[uhq_pkg::UHQ_CTL_RXRST]) begin
        shift_ff <= '0;
        cnt_ff   <= 4'h0;
      end else if (is_spi && cs_rise) begin
        // frame end; only an exact-length frame is delivered
        if (cnt_ff == mode_ff.chlen && !blocked_ff) begin
          rxdata_ff <= uhq_keep(shift_ff, mode_ff.chlen);
        end
        cnt_ff <= 4'h0;
      end else if (sck_rise && rx_en) begin
        shift_ff <= {shift_ff[uhq_pkg::UHQ_SHIFT_W-2:0], lnk_s_ff.rxd};
        if (!is_spi && cnt_inc == mode_ff.chlen) begin
          rxdata_ff <= uhq_keep({shift_ff[uhq_pkg::UHQ_SHIFT_W-2:0], lnk_s_ff.rxd},
                                mode_ff.chlen);
          cnt_ff    <= 4'h0;
        end else if (cnt_ff != 4'hf) begin
          cnt_ff <= cnt_inc;
        end
      end
    end
  end

  // sticky events; a set in the clearing cycle wins
  always_comb begin
    stat_set = '0;
    stat_set[uhq_pkg::UHQ_ST_RXRDY] = ce_i & ~(wr_ctl & wdata_ff[uhq_pkg::UHQ_CTL_RXRST]) &
      ((is_spi & cs_rise & ~blocked_ff & (cnt_ff == mode_ff.chlen)) |
       (~is_spi & sck_rise & rx_en & (cnt_inc == mode_ff.chlen)));
    stat_set[uhq_pkg::UHQ_ST_SPIERR] = ce_i & is_spi & sck_rise & rx_en &
      (cnt_ff == mode_ff.chlen) & ~(wr_ctl & wdata_ff[uhq_pkg::UHQ_CTL_RXRST]);
    stat_clr = wr_stat ? wdata_ff[uhq_pkg::UHQ_ST_W-1:0] : '0;
  end
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff <= '0;
    end else if (ce_i) begin
      stat_ff <= (stat_ff & ~stat_clr) | stat_set;
    end
  end
  assign irq_o = |(stat_ff & mask_ff);

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  sequence s_tx_in_t1;
    tx_t1;
  endsequence
  sequence s_still_locked;
    blocked_ff && !(wr_ctl && unblk_ff == uhq_pkg::UHQ_UNBLK_MODE) && !tx_t1;
  endsequence

  property p_rts_hs_stays_low;
    (!HS_FIXED && mode_ff.mode == uhq_pkg::UHQ_HANDSHAKE && dma_rx_full_i && !nxt_force && ce_i)
      |=> !rts_o;
  endproperty
  a_rts_hs_stays_low: assert property (p_rts_hs_stays_low)
    else $error("rts rose in handshake mode");
  property p_rts_force_high;
    (wr_ctl && wdata_ff[uhq_pkg::UHQ_CTL_RTSHIGH]) |=> rts_o && force_ff;
  endproperty
  a_rts_force_high: assert property (p_rts_force_high)
    else $error("force-high did not raise rts");
  property p_rts_force_low;
    (wr_ctl && wdata_ff[uhq_pkg::UHQ_CTL_RTSLOW] && !wdata_ff[uhq_pkg::UHQ_CTL_RTSHIGH] &&
     !hs_raise) |=> !rts_o;
  endproperty
  a_rts_force_low: assert property (p_rts_force_low)
    else $error("force-low did not lower rts");
  property p_errcnt_zero;
    (rd_take && s_axi_araddr_i == uhq_pkg::UHQ_OFS_ERRCNT) |=> rvalid_ff && rdata_ff == 32'h0;
  endproperty
  a_errcnt_zero: assert property (p_errcnt_zero)
    else $error("error count read nonzero");
  property p_t1_blocks;
    s_tx_in_t1 |=> blocked_ff ##0 !rx_en;
  endproperty
  a_t1_blocks: assert property (p_t1_blocks)
    else $error("t1 transmit did not block receive");
  property p_t1_stays_blocked;
    s_still_locked |=> blocked_ff && $stable(rxdata_ff);
  endproperty
  a_t1_stays_blocked: assert property (p_t1_stays_blocked)
    else $error("receiver unblocked without reconfiguration");
  property p_spi_overlength;
    (ce_i && is_spi && sck_rise && rx_en && cnt_ff == mode_ff.chlen &&
     !(wr_ctl && wdata_ff[uhq_pkg::UHQ_CTL_RXRST])) |=> stat_ff[uhq_pkg::UHQ_ST_SPIERR];
  endproperty
  a_spi_overlength: assert property (p_spi_overlength)
    else $error("overlong spi frame not flagged");
  property p_rts_low_unforced;
    (ce_i && !nxt_force && !hs_raise) |=> !rts_o;
  endproperty
  a_rts_low_unforced: assert property (p_rts_low_unforced)
    else $error("rts high without cause");
endmodule

// ---- testbench/uhq_link_peer.sv ----
// remote serial partner that drives clock, data and select of the link
`timescale 1ns/10ps
module uhq_link_peer (
  // link pins toward the receiver
  output uhq_pkg::uhq_link_t link_o
);
  // slow link clock
  // 800 ns period, four block clocks per level so edges are seen
  localparam time HALF = 400ns;

  // idle: clock still, deselected, data parked high
  initial begin
    link_o.sck = 1'b0;
    link_o.rxd = 1'b1;
    link_o.cs_n = 1'b1;
  end

  // one frame msb first; data only changes while the clock is low
  task automatic send(input logic [8:0] bits, input int n, input bit sel);
    int i;
    #37ns;
    link_o.cs_n = !sel;
    for (i = n - 1; i >= 0; i--) begin
      link_o.rxd = bits[i];
      #HALF;
      link_o.sck = 1'b1;
      #HALF;
      link_o.sck = 1'b0;
    end
    #HALF;
    link_o.cs_n = 1'b1;
    // released data line shows the inverse, never a stale copy
    link_o.rxd = ~link_o.rxd;
  endtask
endmodule

// ---- testbench/uhq_usart_rx_ctrl_bench.sv ----
// self-checking bench of the serial receive-control block
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH at %0t: got %h expected %h", $time, (a), (e)); end end
module uhq_usart_rx_ctrl_bench;
  logic               clock_i;
  logic               arst_n_i;
  logic               awvalid, wvalid, bready, arvalid, rready, dma_full, tx_done;
  logic               ce;
  logic               awready, wready, bvalid, arready, rvalid, rts, irq;
  logic [7:0]         awaddr, araddr;
  logic [31:0]        wdata, rdata;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp, rs;
  uhq_pkg::uhq_link_t link;
  int                 failures = 0;
  int                 tests_run = 0;

  uhq_usart_rx_ctrl #(.HS_FIXED(1'b0)) u_dut (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .ce_i(ce),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .link_i(link), .rts_o(rts),
    .dma_rx_full_i(dma_full), .tx_done_i(tx_done), .irq_o(irq));

  uhq_link_peer u_peer (.link_o(link));

  // 10 MHz block clock
  initial begin
    clock_i = 1'b0;
    forever #50ns clock_i = ~clock_i;
  end

  // one write; address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clock_i);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  // one read, returning data and response
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clock_i);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock_i);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // read and compare data and response
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHK(d, e)
    `CHK(r, er)
  endtask

  // write and expect the given response
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    wr(a, d, rs);
    `CHK(rs, er)
  endtask

  // quiet state after reset, error count and an unmapped place
  task automatic t_reset();
    `CHK(rts, 1'b0)
    `CHK(irq, 1'b0)
    rd_chk(uhq_pkg::UHQ_OFS_ERRCNT, 32'h0, uhq_pkg::UHQ_RESP_OKAY);
    // a write without the low byte lane is ignored yet answered okay
    wstrb <= 4'he;
    wr_chk(uhq_pkg::UHQ_OFS_MODE, 32'h53, uhq_pkg::UHQ_RESP_OKAY);
    wstrb <= 4'hf;
    rd_chk(uhq_pkg::UHQ_OFS_MODE, 32'h80, uhq_pkg::UHQ_RESP_OKAY);
    rd_chk(8'h1c, 32'h0, uhq_pkg::UHQ_RESP_SLVERR);
    wr_chk(8'h20, 32'h1, uhq_pkg::UHQ_RESP_SLVERR);
  endtask

  // software-driven flow control on a full buffer, then handshake mode
  task automatic t_force();
    dma_full <= 1'b1;
    wr_chk(uhq_pkg::UHQ_OFS_CTRL, 32'h4, uhq_pkg::UHQ_RESP_OKAY);
    `CHK(rts, 1'b1)
    rd_chk(uhq_pkg::UHQ_OFS_STATE, 32'h1, uhq_pkg::UHQ_RESP_OKAY);
    dma_full <= 1'b0;
    wr_chk(uhq_pkg::UHQ_OFS_CTRL, 32'h2, uhq_pkg::UHQ_RESP_OKAY);
    `CHK(rts, 1'b0)
    wr_chk(uhq_pkg::UHQ_OFS_CTRL, 32'h6, uhq_pkg::UHQ_RESP_OKAY);
    `CHK(rts, 1'b1)
    rd_chk(uhq_pkg::UHQ_OFS_CTRL, 32'h0, uhq_pkg::UHQ_RESP_OKAY);
    wr_chk(uhq_pkg::UHQ_OFS_CTRL, 32'h2, uhq_pkg::UHQ_RESP_OKAY);
    wr_chk(uhq_pkg::UHQ_OFS_MODE, 32'h81, uhq_pkg::UHQ_RESP_OKAY);
    dma_full <= 1'b1;
    repeat (10) @(posedge clock_i);
    `CHK(rts, 1'b0)
    dma_full <= 1'b0;
  endtask

  // send a frame and compare status and received data
  task automatic frame(input logic [8:0] b, input int n, input bit s,
                       input logic [31:0] st, input logic [31:0] dat);
    wr_chk(uhq_pkg::UHQ_OFS_STAT, 32'h3, uhq_pkg::UHQ_RESP_OKAY);
    u_peer.send(b, n, s);
    repeat (6) @(posedge clock_i);
    rd_chk(uhq_pkg::UHQ_OFS_STAT, st, uhq_pkg::UHQ_RESP_OKAY);
    if (st[0]) rd_chk(uhq_pkg::UHQ_OFS_RXDATA, dat, uhq_pkg::UHQ_RESP_OKAY);
  endtask

  // normal receive with interrupt raise, mask and clear
  task automatic t_rx();
    wr_chk(uhq_pkg::UHQ_OFS_MODE, 32'h80, uhq_pkg::UHQ_RESP_OKAY);
    wr_chk(uhq_pkg::UHQ_OFS_MASK, 32'h1, uhq_pkg::UHQ_RESP_OKAY);
    frame(9'h0a5, 8, 1'b0, 32'h1, 32'h0a5);
    `CHK(irq, 1'b1)
    wr_chk(uhq_pkg::UHQ_OFS_MASK, 32'h0, uhq_pkg::UHQ_RESP_OKAY);
    `CHK(irq, 1'b0)
    wr_chk(uhq_pkg::UHQ_OFS_MASK, 32'h3, uhq_pkg::UHQ_RESP_OKAY);
    `CHK(irq, 1'b1)
    wr_chk(uhq_pkg::UHQ_OFS_STAT, 32'h1, uhq_pkg::UHQ_RESP_OKAY);
    `CHK(irq, 1'b0)
    rd_chk(uhq_pkg::UHQ_OFS_ERRCNT, 32'h0, uhq_pkg::UHQ_RESP_OKAY);
  endtask

  // overlong select frame flags the error; a correct one then lands
  task automatic t_spi();
    wr_chk(uhq_pkg::UHQ_OFS_MODE, 32'h83, uhq_pkg::UHQ_RESP_OKAY);
    frame(9'h1a5, 9, 1'b1, 32'h2, 32'h0);
    `CHK(irq, 1'b1)
    frame(9'h05a, 8, 1'b1, 32'h1, 32'h05a);
  endtask

  // transmit blocks receive until reset, mode and control are rewritten
  task automatic t_t1();
    wr_chk(uhq_pkg::UHQ_OFS_MODE, 32'h82, uhq_pkg::UHQ_RESP_OKAY);
    // a transmit pulse while the clock enable is low must not block
    ce <= 1'b0;
    tx_done <= 1'b1;
    @(posedge clock_i);
    ce <= 1'b1;
    tx_done <= 1'b0;
    rd_chk(uhq_pkg::UHQ_OFS_STATE, 32'h0, uhq_pkg::UHQ_RESP_OKAY);
    tx_done <= 1'b1;
    @(posedge clock_i);
    tx_done <= 1'b0;
    rd_chk(uhq_pkg::UHQ_OFS_STATE, 32'h2, uhq_pkg::UHQ_RESP_OKAY);
    frame(9'h0c3, 8, 1'b0, 32'h0, 32'h0);
    wr_chk(uhq_pkg::UHQ_OFS_CTRL, 32'h1, uhq_pkg::UHQ_RESP_OKAY);
    wr_chk(uhq_pkg::UHQ_OFS_MODE, 32'h82, uhq_pkg::UHQ_RESP_OKAY);
    wr_chk(uhq_pkg::UHQ_OFS_CTRL, 32'h0, uhq_pkg::UHQ_RESP_OKAY);
    rd_chk(uhq_pkg::UHQ_OFS_STATE, 32'h0, uhq_pkg::UHQ_RESP_OKAY);
    frame(9'h03c, 8, 1'b0, 32'h1, 32'h03c);
  endtask

  // counts and verdict, then stop
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clock_i);
    failures++;
    end_of_test();
  end

  // reset, then the scenarios in turn
  initial begin
    arst_n_i = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, dma_full, tx_done} = 7'h00;
    ce = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (5) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    t_reset();
    t_force();
    t_rx();
    t_spi();
    t_t1();
    end_of_test();
  end
endmodule
